// [design/dvr_pkg.sv]
package dvr_pkg;
	// clock and timing
	localparam int unsigned MCLK_HZ        = 50_000_000;
	localparam int unsigned SAMPLE_HZ      = 3_000_000;  // code sampling clock
	localparam int unsigned STEP_HZ        = 330_000;    // slewing step clock
	localparam int unsigned SAMPLE_DIV     = MCLK_HZ / SAMPLE_HZ;  // rounds down
	localparam int unsigned STEP_DIV       = MCLK_HZ / STEP_HZ;
	localparam int unsigned STABLE_READS   = 3;          // equal samples needed
	// reference in units of 6.25 mV (lsb)
	localparam int unsigned REF_W          = 8;
	localparam int unsigned CODE_W         = 8;
	localparam logic [7:0]  REF_RESET      = 8'h00;
	localparam logic [7:0]  STEP_LSB       = 8'h01;      // one 6.25 mV step
	localparam logic [5:0]  SLEW_BASE      = 6'h3C;      // 0.3750 V / 6.25 mV = 60
	localparam logic [7:0]  SLEW_UPPER_TOP = 8'h7C;      // 0.7750 V / 6.25 mV = 124
	localparam logic [7:0]  FINE_STEP      = 8'h02;      // 12.5 mV table step in lsb
	localparam logic [7:0]  COARSE_STEP    = 8'h04;      // 25 mV table step in lsb
	// table modes
	typedef enum logic [1:0] {
		DVR_STEPWISE_A,
		DVR_STEPWISE_B,
		DVR_SLEWED_5,
		DVR_SLEWED_6
	} dvr_mode_t;
	// reference output carrier
	typedef struct packed {
		logic [REF_W-1:0] level;   // reference in 6.25 mV units
		logic             busy;    // slewing in progress
		logic             target;  // reference equals level mapped from validated code
	} dvr_ref_t;
endpackage : dvr_pkg

// [design/dvr_validator.sv]
`timescale 1ns/10ps
// samples the code on sampling ticks and flags a code seen equal three times
module dvr_validator #(
	parameter int unsigned CODE_W = 8,
	parameter int unsigned READS  = 3
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              tick,
	input  wire logic [CODE_W-1:0] code_in,
	output logic                   new_valid,
	output logic      [CODE_W-1:0] code_valid
);
	import dvr_pkg::*;
	localparam int unsigned CW = $clog2(READS + 1);
	logic [CODE_W-1:0] last_q;
	logic [CW-1:0]     cnt_q;
	logic              same;
	logic              hit;

	// refuse a count the compare logic cannot serve
	if (READS < 2) begin : g_reads_chk
		$error("validator needs at least two reads");
	end

	assign same = (code_in == last_q);
	assign hit  = tick && same && (cnt_q == CW'(READS - 1)) && (code_in != code_valid);

	//////////////////////////////////////////////////////////////////////
	// three equal samples
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last_q     <= '0;
			cnt_q      <= '0;
			code_valid <= '0;
			new_valid  <= 1'b0;
		end else begin
			new_valid <= hit;
			if (tick) begin
				last_q <= code_in;
				if (!same)
					cnt_q <= CW'(1);
				else if (cnt_q < CW'(READS))
					cnt_q <= cnt_q + CW'(1);
			end
			if (hit)
				code_valid <= code_in;
		end
	end

	mismatch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(tick && !same) |=> (code_valid == $past(code_valid) && !new_valid)) else $error("code taken on mismatch");
endmodule : dvr_validator

// [design/dvr_ref_ctrl.sv]
`timescale 1ns/10ps
// Overview of operation
// - mode decides: stepwise modes jump, slewed modes ramp to new code.
// - stepwise modes sample the code on each 3 MHz sampling tick.
// - a new code is accepted after three equal consecutive samples.
// - stepwise modes load the reference directly once the code validates.
// - slewed modes sample and validate codes the same way.
// - slewed modes accept multi-step code changes.
// - slewed modes step reference 6.25 mV per 330 kHz tick until equal.
// - slewed tick count equals reference change over 6.25 mV.
// - six-bit slewed mode maps codes through a fixed table, 111111 to 0.375 V.
module dvr_ref_ctrl (
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire dvr_pkg::dvr_mode_t mode,
	input  wire logic [7:0]         voltage_id_code,
	output dvr_pkg::dvr_ref_t       ref_out,
	output logic                    code_accepted
);
	import dvr_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_s1_q;
	logic rst_n;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// tick dividers
	localparam int unsigned SW = $clog2(SAMPLE_DIV);
	localparam int unsigned TW = $clog2(STEP_DIV);
	localparam int          SAMPLE_GAP = int'(SAMPLE_DIV);
	localparam int          STEP_GAP   = int'(STEP_DIV);
	logic [SW-1:0] sdiv_q;
	logic [TW-1:0] tdiv_q;
	logic          sample_tick;
	logic          step_tick;

	if (SAMPLE_DIV < 2 || STEP_DIV < 2) begin : g_div_chk
		$error("clock too slow for tick rates");
	end

	assign sample_tick = (sdiv_q == SW'(SAMPLE_DIV - 1));
	assign step_tick   = (tdiv_q == TW'(STEP_DIV - 1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdiv_q <= '0;
			tdiv_q <= '0;
		end else begin
			sdiv_q <= sample_tick ? '0 : sdiv_q + SW'(1);
			tdiv_q <= step_tick ? '0 : tdiv_q + TW'(1);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// code validation
	logic       new_valid;
	logic [7:0] code_valid;

	dvr_validator #(
		.CODE_W (CODE_W),
		.READS  (STABLE_READS)
	) u_dvr_validator (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.tick       (sample_tick),
		.code_in    (voltage_id_code),
		.new_valid  (new_valid),
		.code_valid (code_valid)
	);

	//////////////////////////////////////////////////////////////////////
	// code to reference level (6.25 mV units)
	// code to level table
	function automatic logic [7:0] code_level(input dvr_mode_t m, input logic [7:0] c);
		logic [4:0] inv;
		logic [7:0] lvl;
		inv = ~c[4:0];  // inverted in 5 bits, so no ones spill into the upper bits
		lvl = 8'h00;
		case (m)
			DVR_SLEWED_6: begin
				// 1xxxxx: 12.5 mV steps above 0.375 V, 0xxxxx: 25 mV steps above 0.775 V
				if (c[5])
					lvl = 8'(SLEW_BASE) + FINE_STEP * 8'(inv);
				else
					lvl = SLEW_UPPER_TOP + COARSE_STEP * 8'(inv);
			end
			DVR_SLEWED_5:
				lvl = SLEW_UPPER_TOP + COARSE_STEP * 8'(inv);
			default:
				lvl = c;  // stepwise modes: code value is the level index
		endcase
		return lvl;
	endfunction : code_level

	wire       slewed     = (mode == DVR_SLEWED_5) || (mode == DVR_SLEWED_6);
	wire [7:0] target_lvl = code_level(mode, code_valid);

	//////////////////////////////////////////////////////////////////////
	// reference update
	typedef enum logic [1:0] {DVR_IDLE, DVR_SLEW} dvr_state_t;
	dvr_state_t state_q;
	dvr_state_t state_d;
	logic [7:0] ref_q;
	logic [7:0] ref_d;

	always_comb begin
		state_d = state_q;
		ref_d   = ref_q;
		case (state_q)
			DVR_IDLE: begin
				if (new_valid && !slewed)
					ref_d = target_lvl;
				else if (new_valid)
					state_d = DVR_SLEW;
			end
			DVR_SLEW: begin
				if (ref_q == target_lvl)
					state_d = DVR_IDLE;
				else if (step_tick)
					ref_d = (ref_q < target_lvl) ? ref_q + STEP_LSB : ref_q - STEP_LSB;
				if (!slewed)
					state_d = DVR_IDLE;
			end
			default: state_d = DVR_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= DVR_IDLE;
			ref_q   <= REF_RESET;
		end else begin
			state_q <= state_d;
			ref_q   <= ref_d;
		end
	end

	assign ref_out.level  = ref_q;
	assign ref_out.busy   = (state_q == DVR_SLEW);
	assign ref_out.target = (ref_q == target_lvl);
	assign code_accepted  = new_valid;

	//////////////////////////////////////////////////////////////////////
	// checks
	// stepwise jump
	step_jump_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(new_valid && !slewed && state_q == DVR_IDLE) |=> (ref_q == $past(target_lvl)))
		else $error("stepwise reference not loaded");
	// slew moves one lsb only on step tick
	slew_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_SLEW && slewed && ref_q != target_lvl && step_tick) |=>
		(ref_q == $past(ref_q) + STEP_LSB || ref_q == $past(ref_q) - STEP_LSB))
		else $error("slew step wrong");
	slew_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_SLEW && !step_tick) |=> $stable(ref_q))
		else $error("reference moved between ticks");
	table_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode == DVR_SLEWED_6 && code_valid[5:0] == 6'h3F) |-> (target_lvl == 8'(SLEW_BASE)))
		else $error("table end wrong");
	sample_rate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_tick |=> !sample_tick [*2]) else $error("sample ticks too close");
	// acceptance only on a sampling tick edge
	accept_tick_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(new_valid) |-> $past(sample_tick)) else $error("accept off tick");
	busy_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_SLEW && ref_q == target_lvl) |=> !ref_out.busy)
		else $error("slew did not stop at target");
	slew_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_SLEW && slewed && ref_q < target_lvl && step_tick) |=>
		(ref_q == $past(ref_q) + STEP_LSB))
		else $error("slew step not upward");
	slew_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_SLEW && slewed && ref_q > target_lvl && step_tick) |=>
		(ref_q == $past(ref_q) - STEP_LSB))
		else $error("slew step not downward");
	slew_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_IDLE && new_valid && slewed) |=> ref_out.busy)
		else $error("slew not started");
	// reference holds in idle without a validated code
	idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == DVR_IDLE && !new_valid) |=> $stable(ref_q))
		else $error("reference moved while idle");
	sample_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_tick |-> ##SAMPLE_GAP sample_tick) else $error("sampling tick period wrong");
	step_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
		step_tick |-> ##STEP_GAP step_tick) else $error("stepping tick period wrong");

	cover_jump_c: cover property (@(posedge mclk) disable iff (!rst_n) new_valid && !slewed);
	cover_slew_c: cover property (@(posedge mclk) disable iff (!rst_n) $fell(ref_out.busy));
	cover_down_c: cover property (@(posedge mclk) disable iff (!rst_n)
		ref_out.busy && step_tick && ref_q > target_lvl);
	cover_up_c: cover property (@(posedge mclk) disable iff (!rst_n)
		ref_out.busy && step_tick && ref_q < target_lvl);
	cover_five_c: cover property (@(posedge mclk) disable iff (!rst_n)
		ref_out.busy && mode == DVR_SLEWED_5);
endmodule : dvr_ref_ctrl

// [dv/dvr_cpu_model.sv]
`timescale 1ns/10ps
// processor side: drives the code lines after each clock edge
module dvr_cpu_model #(
	parameter int unsigned GAP = 300
) (
	input  wire logic       mclk,
	input  wire logic       jump,
	input  wire logic [7:0] want,
	output logic      [7:0] voltage_id_code
);
	int unsigned wait_q = 0;

	initial voltage_id_code = 8'h00;
	// code update per clock, spacing held by the gap counter
	// single steps, gap apart
	// jump straight to a multi-step target
	always @(posedge mclk) begin
		if (jump) begin
			voltage_id_code <= #1 want;
		end else if (wait_q != 0) begin
			wait_q <= wait_q - 1;
		end else if (voltage_id_code != want) begin
			voltage_id_code <= #1 (voltage_id_code < want) ? voltage_id_code + 8'h01 : voltage_id_code - 8'h01;
			wait_q <= GAP;
		end
	end
endmodule : dvr_cpu_model

// [dv/dynamic_vid_reference_control_tb_top.sv]
`timescale 1ns/10ps
// bench for the reference control block
module dynamic_vid_reference_control_tb_top;
	import dvr_pkg::*;
	logic       mclk = 1'b0;
	logic       resetn = 1'b0;
	dvr_mode_t  mode = DVR_STEPWISE_A;
	logic       jump = 1'b0;
	logic [7:0] want = 8'h00;
	logic [7:0] voltage_id_code;
	dvr_ref_t   ref_out;
	logic       code_accepted;
	int         mismatches = 0;
	int         n_tests = 0;
	int         cycles = 0;
	bit         got;

	dvr_ref_ctrl u_dvr_ref_ctrl (.mclk(mclk), .resetn(resetn), .mode(mode),
		.voltage_id_code(voltage_id_code), .ref_out(ref_out), .code_accepted(code_accepted));
	dvr_cpu_model #(.GAP(300)) u_dvr_cpu_model (.mclk(mclk), .jump(jump), .want(want),
		.voltage_id_code(voltage_id_code));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	task automatic drive(input dvr_mode_t m, input logic j, input logic [7:0] w);
		@(posedge mclk);
		#1;
		mode = m;
		jump = j;
		want = w;
	endtask : drive

	task automatic wait_accept;
		got = 0;
		repeat (500) begin
			@(negedge mclk);
			if (code_accepted === 1'b1) begin
				got = 1;
				break;
			end
		end
	endtask : wait_accept

	// stepwise: each single step is loaded whole, one cycle after the pulse
	task automatic stepwise(input dvr_mode_t m, input logic [7:0] from, input logic [7:0] to);
		logic [7:0] exp;
		exp = from;
		drive(m, 1'b0, to);
		while (exp != to) begin
			wait_accept();
			check("accept", 8'(got), 8'h01);
			check("level held", ref_out.level, exp);
			exp = (exp < to) ? exp + 8'h01 : exp - 8'h01;
			@(negedge mclk);
			check("level loaded", ref_out.level, exp);
			check("accept pulse", 8'(code_accepted), 8'h00);
		end
	endtask : stepwise

	// a short-lived code must not be taken
	task automatic glitch(input logic [7:0] keep);
		drive(mode, 1'b1, keep + 8'h01);
		repeat (20) @(posedge mclk);
		drive(mode, 1'b1, keep);
		wait_accept();
		check("glitch accept", 8'(got), 8'h00);
		check("glitch level", ref_out.level, keep);
	endtask : glitch

	// slewed: one lsb per step until the level reaches the target
	task automatic slew(input dvr_mode_t m, input logic [7:0] code, input logic [7:0] start, input logic [7:0] target);
		int         steps;
		int         cyc;
		logic [7:0] prev;
		steps = 0;
		cyc = 0;
		prev = start;
		drive(m, 1'b1, code);
		wait_accept();
		check("slew accept", 8'(got), 8'h01);
		@(negedge mclk);
		while (ref_out.busy === 1'b1 && cyc < 20000) begin
			@(negedge mclk);
			cyc++;
			if (ref_out.level !== prev) begin
				steps++;
				check("step", ref_out.level, (prev < target) ? prev + 8'h01 : prev - 8'h01);
				prev = ref_out.level;
			end
		end
		check("steps", 8'(steps), (target > start) ? target - start : start - target);
		check("final", ref_out.level, target);
		check("at target", 8'(ref_out.target), 8'h01);
		check("duration", 8'(cyc <= (steps + 1) * 151), 8'h01);
	endtask : slew

	// clock
	initial begin
		forever #10 mclk = ~mclk;
	end

	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			finish_test();
		end
	end

	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		#1;
		resetn = 1'b1;
		@(negedge mclk);
		check("reset level", ref_out.level, REF_RESET);
		check("reset busy", 8'(ref_out.busy), 8'h00);
		check("reset accept", 8'(code_accepted), 8'h00);
		stepwise(DVR_STEPWISE_A, 8'h00, 8'h03);
		glitch(8'h03);
		stepwise(DVR_STEPWISE_B, 8'h03, 8'h01);
		slew(DVR_SLEWED_6, 8'h3F, 8'h01, 8'h3C);
		slew(DVR_SLEWED_6, 8'h3C, 8'h3C, 8'h42);
		slew(DVR_SLEWED_6, 8'h3E, 8'h42, 8'h3E);
		// five-bit code 11111 sits at the 0.775 V base, 124 lsb
		slew(DVR_SLEWED_5, 8'h1F, 8'h3E, 8'h7C);
		check("five bit accept", 8'(got), 8'h01);
		finish_test();
	end
endmodule : dynamic_vid_reference_control_tb_top
